// file: logic/srw_watchdog.v
// Purpose: countdown watchdog recovering a hung system by reset or nmi
// Assumes: load strobe and config inputs synchronous to i_mclk
// Notes:   all outputs are registered; expiry gives one pulse
//
// Operation
// - On expiry the block recovers the system by a cold reset or an nmi.
// - Loading a nonzero count starts a countdown from that value.
// - When the running count reaches zero the action selected by i_act_nmi (cold reset or nmi) fires.
// - Every load restarts the countdown; software must reload in time.
// - Loading zero disables the block so nothing is produced.
// - The count is in units picked by a unit-select option, seconds base.
`include "srw_map.vh"

module srw_watchdog #(
  parameter integer SEC_CYCLES = `SRW_SEC_CYCLES,
  parameter integer UNITS_PER_MIN = `SRW_SEC_PER_MIN
) (
  input  wire       i_mclk,
  input  wire       i_arst_n,
  input  wire       i_load,
  input  wire [7:0] i_timeout_count_operand,
  input  wire       i_unit_minutes,
  input  wire       i_act_nmi,
  output reg        o_cold_reset,
  output reg        o_nmi,
  output reg        o_running,
  output reg  [7:0] o_count
);

  // ----------------------------------------------------------------------
  // per-second tick divider
  // ----------------------------------------------------------------------
  reg [31:0] sec_div_reg;
  reg        sec_tick_reg;
  reg [7:0]  min_div_reg;
  wire       restart = i_load;

  // one-cycle enable each second, realigned on every load
  always @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sec_div_reg  <= 32'h0000_0000;
      sec_tick_reg <= 1'b0;
    end else if (restart) begin
      sec_div_reg  <= 32'h0000_0000;
      sec_tick_reg <= 1'b0;
    end else if (sec_div_reg == SEC_CYCLES[31:0] - 32'h0000_0001) begin
      sec_div_reg  <= 32'h0000_0000;
      sec_tick_reg <= 1'b1;
    end else begin
      sec_div_reg  <= sec_div_reg + 32'h0000_0001;
      sec_tick_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // unit select
  // ----------------------------------------------------------------------
  // minute prescaler counts seconds in both units; only minutes mode uses it
  always @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n)
      min_div_reg <= 8'h00;
    else if (restart)
      min_div_reg <= 8'h00;
    else if (sec_tick_reg) begin
      if (min_div_reg == UNITS_PER_MIN[7:0] - 8'h01)
        min_div_reg <= 8'h00;
      else
        min_div_reg <= min_div_reg + 8'h01;
    end
  end

  wire unit_tick = (i_unit_minutes == `SRW_UNIT_MINUTES) ?
                   (sec_tick_reg &&
                    min_div_reg == UNITS_PER_MIN[7:0] - 8'h01) :
                   sec_tick_reg;

  // ----------------------------------------------------------------------
  // countdown and expiry
  // ----------------------------------------------------------------------
  reg [7:0] count_next;
  reg       run_next;
  reg       expire;

  // load wins over a tick in the same cycle
  always @* begin
    count_next = o_count;
    run_next   = o_running;
    expire     = 1'b0;
    if (i_load) begin
      count_next = i_timeout_count_operand;
      run_next   = |i_timeout_count_operand;
    end else if (o_running && unit_tick) begin
      count_next = o_count - 8'h01;
      if (o_count == 8'h01) begin
        run_next = 1'b0;
        expire   = 1'b1;
      end
    end
  end

  // state and one-cycle recovery pulses
  always @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_count      <= `SRW_COUNT_RST;
      o_running    <= 1'b0;
      o_cold_reset <= 1'b0;
      o_nmi        <= 1'b0;
    end else begin
      o_count      <= count_next;
      o_running    <= run_next;
      o_cold_reset <= expire && (i_act_nmi == `SRW_ACT_RESET);
      o_nmi        <= expire && (i_act_nmi == `SRW_ACT_NMI);
    end
  end

endmodule

// file: logic/srw_map.vh
// Purpose: constants for the system recovery watchdog
// Assumes: 100 MHz system clock
// Notes:   counts are in clock cycles unless named otherwise
`ifndef SRW_MAP_VH
`define SRW_MAP_VH

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define SRW_CLK_HZ        100000000
`define SRW_SEC_CYCLES    (`SRW_CLK_HZ * 1)
`define SRW_SEC_PER_MIN   60

// ----------------------------------------------------------------------
// configuration values
// ----------------------------------------------------------------------
`define SRW_UNIT_SECONDS  1'b0
`define SRW_UNIT_MINUTES  1'b1
`define SRW_ACT_RESET     1'b0
`define SRW_ACT_NMI       1'b1
`define SRW_COUNT_RST     8'h00
`define SRW_COUNT_W       8

`endif

// file: test/srw_watchdog_sva.sv
// Purpose: port assertions for the watchdog
// Assumes: reset and clock as on the ports
// Notes:   bound below
module srw_sva (input wire logic i_mclk, i_arst_n, i_load, i_act_nmi,
  input wire logic i_unit_minutes, o_cold_reset, o_nmi, o_running,
  input wire logic [7:0] i_timeout_count_operand, o_count);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_arst_n);
  property p_ld; i_load |=> o_count == $past(i_timeout_count_operand) &&
    o_running == (o_count != 8'h00); endproperty
  a_ld: assert property (p_ld) else $error("load");
  property p_zero; i_load && i_timeout_count_operand == 8'h00 |=>
    !o_running ##1 !o_cold_reset && !o_nmi; endproperty
  a_zero: assert property (p_zero) else $error("zero");
  property p_idle; !o_running |-> o_count == 8'h00; endproperty
  a_idle: assert property (p_idle) else $error("idle");
  property p_step; o_running && !i_load |=> o_count == $past(o_count)
    || o_count == $past(o_count) - 8'h01; endproperty
  a_step: assert property (p_step) else $error("step");
  property p_exp; $fell(o_running) && !$past(i_load) |->
    o_nmi ^ o_cold_reset && o_nmi == $past(i_act_nmi); endproperty
  a_exp: assert property (p_exp) else $error("expiry");
  property p_one; o_cold_reset || o_nmi |=> !o_cold_reset && !o_nmi;
  endproperty
  a_one: assert property (p_one) else $error("pulse");
  property p_src; o_cold_reset || o_nmi |-> $past(o_running) &&
    $past(o_count) == 8'h01;
  endproperty
  a_src: assert property (p_src) else $error("cause");
  property p_excl; !(o_cold_reset && o_nmi); endproperty
  a_excl: assert property (p_excl) else $error("both");
endmodule
bind srw_watchdog srw_sva u_srw_sva (.*);

// file: test/srw_watchdog_tb.sv
// Purpose: self-checking bench for srw_watchdog
// Assumes: ten cycle second, three second minute
// Notes:   model compared every cycle
module srw_watchdog_tb;
  timeunit 1ns; timeprecision 1ns;
  logic i_mclk = 0, i_arst_n = 0, i_load = 0, i_unit_minutes = 0;
  logic i_act_nmi = 0; logic [7:0] v = 0;
  wire o_cold_reset, o_nmi, o_running; wire [7:0] o_count;
  int error_cnt, comparisons, seed = 32'h2b26, m_cnt, m_div, k;
  bit m_run, m_pls, m_act;
  always #5 i_mclk = ~i_mclk;
  srw_watchdog #(.SEC_CYCLES(10), .UNITS_PER_MIN(3)) u_srw_watchdog (.i_mclk,
    .i_arst_n, .i_load, .i_timeout_count_operand(v), .i_unit_minutes,
    .i_act_nmi, .o_cold_reset, .o_nmi, .o_running, .o_count);
  task check(string s, logic [7:0] g, e);
    comparisons++;
    if (g !== e) begin
      error_cnt++; $display("Error %s exp %h got %h", s, e, g); end
  endtask
  // model: load wins, first unit one cycle late, pulse with the zero count
  always @(posedge i_mclk) begin
    m_pls = 0;
    if (i_load) begin m_cnt = v; m_run = v != 0; m_div = -1; end
    else if (m_run && ++m_div == (i_unit_minutes ? 30 : 10)) begin
      m_div = 0; m_cnt--; m_run = m_cnt != 0; m_pls = !m_run;
      m_act = i_act_nmi; end
    if (!i_arst_n) begin m_cnt = 0; m_run = 0; m_pls = 0; end
    #2 check("count", o_count, m_cnt[7:0]);
    check("run", o_running, m_run);
    check("reset", o_cold_reset, m_pls & !m_act);
    check("nmi", o_nmi, m_pls & m_act);
  end
  task ld(logic [7:0] n, int w);
    @(posedge i_mclk) #1 i_load = 1;
    v = n; {i_unit_minutes, i_act_nmi} = 2'($random(seed));
    @(posedge i_mclk) #1 i_load = 0;
    repeat (w) @(posedge i_mclk);
  endtask
  task summarize;
    if (error_cnt == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin #50000; error_cnt++; summarize; end
  initial begin
    repeat (3) @(posedge i_mclk);
    #1 i_arst_n = 1;
    for (k = 0; k < 8; k++) ld(8'h01 + 8'({$random(seed)} % 3), 100);
    ld(8'h02, 14); ld(8'h02, 14); ld(8'hff, 30);
    ld(8'h00, 80);
    summarize;
  end
endmodule
